// file: include/keypad_pkg.sv
// Constants, types and register layout for the keypad wake interrupt block
package keypad_pkg;
  localparam int NUM_PINS = 6;
  localparam logic [0:0] ADDR_STATUS_CONTROL = 1'h0;
  localparam logic [0:0] ADDR_PIN_ENABLE = 1'h1;
  localparam int BIT_PENDING = 3;
  localparam int BIT_ACK = 2;
  localparam int BIT_MASK = 1;
  localparam int BIT_MODE = 0;
  localparam int BIT_WAKE_EN = 6;
  localparam logic [15:0] VECTOR_ADDR = 16'hffe0;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef struct packed {
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] prev;
    logic prev_any_low;
    logic pin_latch;
    logic ack_seen;
    logic wake_latch;
    logic wake_prev;
    logic mode;
    logic mask;
    logic [NUM_PINS:0] enable;
    logic [7:0] rdata;
  } key_state_t;
endpackage

// file: core/keypad_wake_interrupt.sv
// Keypad wake interrupt: pin and wakeup request latch with register port
`timescale 1ns/1ps
module keypad_wake_interrupt
  import keypad_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Register port
  input wire logic i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Pins and wakeup
  input wire logic [NUM_PINS-1:0] i_key_pin,
  input wire logic i_wakeup_timer_request,
  // System
  input wire logic i_vector_fetch,
  input wire logic i_break_state,
  input wire logic i_break_clear_enable,
  input wire logic [NUM_PINS-1:0] i_port_direction,
  input wire logic [NUM_PINS-1:0] i_port_pullup_enable,
  // Outputs
  output logic o_irq,
  output logic o_wakeup,
  output logic [15:0] o_vector_addr,
  output logic [NUM_PINS-1:0] o_pullup_on,
  output logic [NUM_PINS-1:0] o_force_input,
  output logic [NUM_PINS-1:0] o_pin_readable,
  output logic o_wakeup_timer_enable
);

  ////////////////////////////////////////////////////////////////////////////
  key_state_t st_ff;
  key_state_t nxt_st;
  logic [NUM_PINS-1:0] en_pins;
  logic any_low;
  logic fall;
  logic sw_ack;
  logic ack;
  logic pending;

  assign en_pins = st_ff.enable[NUM_PINS-1:0];
  assign any_low = |(~st_ff.sync2 & en_pins);
  // New low only when all enabled were high before
  assign fall = any_low && !st_ff.prev_any_low;
  // Break protects latch from software ack unless clear enabled
  assign sw_ack = i_wr && (i_addr == ADDR_STATUS_CONTROL) && i_wdata[BIT_ACK] &&
                  (!i_break_state || i_break_clear_enable);
  assign ack = sw_ack || i_vector_fetch;
  assign pending = st_ff.pin_latch || st_ff.wake_latch;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = i_key_pin;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev_any_low = any_low;
    nxt_st.wake_prev = i_wakeup_timer_request;
    // Pin latch: edge mode clears at once; level mode needs release too
    // Level mode remembers an ack given while a key is still down
    if (ack && st_ff.mode && any_low && st_ff.pin_latch) begin
      nxt_st.ack_seen = 1'b1;
    end
    if (ack && (!st_ff.mode || !any_low)) begin
      nxt_st.pin_latch = 1'b0;
    end
    if (st_ff.mode && st_ff.ack_seen && !any_low) begin
      nxt_st.pin_latch = 1'b0;
    end
    if (fall || (st_ff.mode && any_low)) begin
      nxt_st.pin_latch = 1'b1;
    end
    if (!nxt_st.pin_latch) begin
      nxt_st.ack_seen = 1'b0;
    end
    // Wakeup input ignores vector fetch
    if (sw_ack) begin
      nxt_st.wake_latch = 1'b0;
    end
    if (st_ff.enable[BIT_WAKE_EN] && i_wakeup_timer_request &&
        (!st_ff.wake_prev || (st_ff.mode && !sw_ack))) begin
      nxt_st.wake_latch = 1'b1; // A new request edge wins over clear; in level mode a held request yields to sw_ack for that cycle
    end
    if (i_wr && i_addr == ADDR_STATUS_CONTROL) begin
      nxt_st.mask = i_wdata[BIT_MASK];
      nxt_st.mode = i_wdata[BIT_MODE];
    end
    if (i_wr && i_addr == ADDR_PIN_ENABLE) begin
      nxt_st.enable = i_wdata[NUM_PINS:0];
    end
    nxt_st.rdata = ZERO_BYTE;
    if (i_rd) begin
      if (i_addr == ADDR_STATUS_CONTROL) begin
        // Upper bits and acknowledge read zero
        nxt_st.rdata[BIT_PENDING] = pending;
        nxt_st.rdata[BIT_MASK] = st_ff.mask;
        nxt_st.rdata[BIT_MODE] = st_ff.mode;
      end else begin
        nxt_st.rdata[NUM_PINS:0] = st_ff.enable;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_rdata = st_ff.rdata;
  // Decoded from the registered latches, so a stop-mode wake needs clock edges first
  assign o_irq = pending && !st_ff.mask;
  assign o_wakeup = pending && !st_ff.mask;
  assign o_vector_addr = VECTOR_ADDR;
  assign o_pullup_on = en_pins | i_port_pullup_enable;
  assign o_force_input = en_pins;
  assign o_pin_readable = ~i_port_direction;
  assign o_wakeup_timer_enable = st_ff.enable[BIT_WAKE_EN];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence edge_ack_s;
    !st_ff.mode && ack && !fall;
  endsequence

  edge_ack_clears_a: assert property (edge_ack_s |=> !st_ff.pin_latch)
    else $error("edge mode ack did not clear pin request");
  level_holds_a: assert property (st_ff.mode && any_low |=> st_ff.pin_latch)
    else $error("level request dropped while pin low");
  fall_latches_a: assert property (fall |=> st_ff.pin_latch)
    else $error("falling input not latched");
  mask_gates_a: assert property (st_ff.mask |-> !o_irq)
    else $error("masked request reached processor");
  fetch_keeps_wake_a: assert property (st_ff.wake_latch && !sw_ack |=> st_ff.wake_latch)
    else $error("wakeup request cleared without software ack");
  break_protect_a: assert property (i_break_state && !i_break_clear_enable && !i_vector_fetch
    && st_ff.pin_latch |=> st_ff.pin_latch)
    else $error("latch cleared during protected break");
  ack_reads_zero_a: assert property (i_rd |=> !o_rdata[BIT_ACK] && o_rdata[7:4] == 4'h0)
    else $error("ack or unused bits read nonzero");
  pending_read_a: assert property (i_rd && i_addr == ADDR_STATUS_CONTROL
    |=> o_rdata[BIT_PENDING] == $past(pending))
    else $error("pending flag read wrong");
  pullup_forced_a: assert property (&(~en_pins | o_pullup_on))
    else $error("enabled pin lacks pullup");
  level_release_a: assert property (st_ff.mode && st_ff.ack_seen && !any_low && !fall
    |=> !st_ff.pin_latch)
    else $error("level request kept after ack and release");
endmodule

// file: sim/keypad_model.sv
// Keypad partner: switches to ground on pins that the block pulls up
`timescale 1ns/1ps
module keypad_model
  import keypad_pkg::*;
(
  // Keys held down
  input wire logic [NUM_PINS-1:0] i_press,
  // Pin levels
  output logic [NUM_PINS-1:0] o_pin
);
  // Released key floats to its pullup level
  assign o_pin = ~i_press;
endmodule

// file: sim/test_keypad_wake_interrupt.sv
// Bench for the keypad wake interrupt block
`timescale 1ns/1ps
module test_keypad_wake_interrupt
  import keypad_pkg::*;
;
  logic clk = 0, rst_n = 0, a = 0, wr = 0, rd = 0, vf = 0, brk = 0, bce = 0, wk = 0;
  logic [7:0] wd = 8'h00, rdat;
  logic [5:0] press = 6'h00, dir = 6'h15, pue = 6'h01, pin, pu, fi, pr;
  logic irq, wake, wte;
  logic [15:0] vec;
  int error_cnt = 0, tests_run = 0, cnt = 0;
  always #20 clk = ~clk;
  keypad_model kp(.i_press(press), .o_pin(pin));
  keypad_wake_interrupt dut(.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(a), .i_wdata(wd),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdat), .i_key_pin(pin), .i_wakeup_timer_request(wk),
    .i_vector_fetch(vf), .i_break_state(brk), .i_break_clear_enable(bce),
    .i_port_direction(dir), .i_port_pullup_enable(pue), .o_irq(irq), .o_wakeup(wake),
    .o_vector_addr(vec), .o_pullup_on(pu), .o_force_input(fi), .o_pin_readable(pr),
    .o_wakeup_timer_enable(wte));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr1(input logic ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd1(input logic ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdat, e, "rdata");
  endtask
  // Sync plus latch takes three edges; four leaves margin
  task automatic key(input logic [5:0] p, input logic e);
    @(posedge clk);
    press <= p;
    repeat (4) @(posedge clk);
    #1 chk(irq, e, "irq");
  endtask
  task automatic fetch;
    @(posedge clk);
    vf <= 1'b1;
    @(posedge clk);
    vf <= 1'b0;
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cnt++;
    if (cnt == 2000) begin
      error_cnt++;
      summarize;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd1(1'b0, 8'h00);
    rd1(1'b1, 8'h00);
    wr1(1'b0, 8'h02);
    wr1(1'b1, 8'h3f);
    wr1(1'b0, 8'h06);
    wr1(1'b0, 8'h00);
    key(6'h01, 1'b1);
    chk(vec, 16'hffe0, "vector");
    rd1(1'b0, 8'h08);
    fetch;
    #1 chk(irq, 1'b0, "irq");
    key(6'h03, 1'b0);
    key(6'h00, 1'b0);
    wr1(1'b0, 8'h01);
    key(6'h04, 1'b1);
    wr1(1'b0, 8'h05);
    key(6'h04, 1'b1);
    key(6'h00, 1'b0);
    wr1(1'b0, 8'h02);
    key(6'h08, 1'b0);
    rd1(1'b0, 8'h0a);
    @(posedge clk) brk <= 1'b1;
    wr1(1'b0, 8'h06);
    rd1(1'b0, 8'h0a);
    @(posedge clk) bce <= 1'b1;
    wr1(1'b0, 8'h06);
    @(posedge clk) brk <= 1'b0;
    rd1(1'b0, 8'h02);
    wr1(1'b0, 8'h00);
    key(6'h00, 1'b0);
    key(6'h08, 1'b1);
    wr1(1'b0, 8'h04);
    wr1(1'b1, 8'h3e);
    #1 chk(pu, 6'h3f, "pullup");
    chk(fi, 6'h3e, "force_in");
    chk(pr, 6'h2a, "readable");
    key(6'h01, 1'b0);
    wr1(1'b1, 8'h40);
    #1 chk(wte, 1'b1, "wake_en");
    @(posedge clk) wk <= 1'b1;
    key(6'h00, 1'b1);
    chk(wake, 1'b1, "wakeup");
    fetch;
    @(posedge clk) wk <= 1'b0;
    key(6'h00, 1'b1);
    wr1(1'b0, 8'h04);
    key(6'h00, 1'b0);
    wr1(1'b0, 8'h01);
    wr1(1'b1, 8'h3f);
    key(6'h01, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    key(6'h01, 1'b0);
    @(posedge clk) rst_n <= 1'b1;
    rd1(1'b0, 8'h00);
    summarize;
  end
endmodule
